// ### pkg/flash_host_defs.svh
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// Word addresses and command codes of the flash bus
`define ADDR_UNLOCK1 22'h000555
`define ADDR_UNLOCK2 22'h0002aa
`define DATA_UNLOCK1 16'h00aa
`define DATA_UNLOCK2 16'h0055
`define CMD_PROGRAM 16'h00a0
`define CMD_BUF_LOAD 16'h0025
`define CMD_BUF_COMMIT 16'h0029
`define CMD_RESET 16'h00f0
`define CMD_BYPASS 16'h0020
`define CMD_AUTOSEL 16'h0090
`define CMD_EXIT_DATA 16'h0000
`define CMD_ERASE_SETUP 16'h0080
`define CMD_CHIP_ERASE 16'h0010
`define CMD_SECTOR_ERASE 16'h0030
`define CMD_SUSPEND 16'h00b0
`define CMD_RESUME 16'h0030
`define CMD_SECURE_ENTER 16'h0088
`define ADDR_ZERO 22'h000000
`define ID_MAKER_OFS 22'h000000
`define ID_PART1_OFS 22'h000001
`define ID_PART2_OFS 22'h00000e
`define ID_PART3_OFS 22'h00000f
`define ID_PROT_OFS 22'h000002
`define SECTOR_LSB 15

// Bus cycle and command settle timing at 125 MHz (8 ns period)
`define CLK_PERIOD_NS 8
`define T_SETUP_NS 40
`define T_PULSE_NS 40
`define T_HOLD_NS 24
`define T_READ_NS 96
`define T_SUSPEND_US 20
`define T_ACCEPT_US 50

`endif

// ### pkg/flash_host_pkg.sv
package flash_host_pkg;
   // Host command selecting one bus sequence
   typedef enum logic [3:0] {
      op_read = 4'h0,
      op_program = 4'h1,
      op_buf_start = 4'h2,
      op_buf_word = 4'h3,
      op_buf_commit = 4'h4,
      op_buf_abort = 4'h5,
      op_bypass_enter = 4'h6,
      op_bypass_program = 4'h7,
      op_bypass_exit = 4'h8,
      op_chip_erase = 4'h9,
      op_sector_erase = 4'ha,
      op_suspend = 4'hb,
      op_resume = 4'hc,
      op_secure_enter = 4'hd,
      op_secure_exit = 4'he,
      op_ident = 4'hf
   } op_type;
endpackage : flash_host_pkg

// ### logic/flash_bus_cycle.sv
`timescale 1ns/1ps
`include "flash_host_defs.svh"

module flash_bus_cycle (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // Cycle request
   input wire logic i_start,
   input wire logic i_write,
   input wire logic [21:0] i_addr,
   input wire logic [15:0] i_data,
   output logic o_done,
   output logic [15:0] o_rdata,
   // Flash pins
   output logic o_ce_n,
   output logic o_we_n,
   output logic o_oe_n,
   output logic [21:0] o_addr,
   output logic [15:0] o_dq_out,
   output logic o_dq_oe,
   input wire logic [15:0] i_dq_in
);
   localparam int SETUP_CYC =
      (`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int PULSE_CYC =
      (`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int HOLD_CYC =
      (`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int READ_CYC =
      (`T_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_setup = 4'h2,
      st_pulse = 4'h4,
      st_hold = 4'h8
   } cyc_state_type;

   cyc_state_type state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic write_q, write_d;
   logic [21:0] addr_q, addr_d;
   logic [15:0] wdata_q, wdata_d;
   logic [15:0] rdata_q, rdata_d;
   logic done_q, done_d;
   logic [15:0] dq_s1_q, dq_s2_q;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      write_d = write_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      done_d = 1'b0;
      unique case (state_q)
         st_idle: begin
            if (i_start) begin
               write_d = i_write;
               addr_d = i_addr;
               wdata_d = i_data;
               cnt_d = 5'(SETUP_CYC);
               state_d = st_setup;
            end
         end
         st_setup: begin
            if (cnt_q <= 5'h01) begin
               // Reads wait out access plus the synchroniser
               cnt_d = write_q ? 5'(PULSE_CYC) : 5'(READ_CYC + 2);
               state_d = st_pulse;
            end else begin
               cnt_d = cnt_q - 5'h01;
            end
         end
         st_pulse: begin
            if (cnt_q <= 5'h01) begin
               if (!write_q) begin
                  rdata_d = dq_s2_q;
               end
               cnt_d = 5'(HOLD_CYC);
               state_d = st_hold;
            end else begin
               cnt_d = cnt_q - 5'h01;
            end
         end
         st_hold: begin
            if (cnt_q <= 5'h01) begin
               done_d = 1'b1;
               state_d = st_idle;
            end else begin
               cnt_d = cnt_q - 5'h01;
            end
         end
         default: state_d = st_idle;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_q <= st_idle;
         cnt_q <= 5'h00;
         write_q <= 1'b0;
         addr_q <= 22'h000000;
         wdata_q <= 16'h0000;
         rdata_q <= 16'h0000;
         done_q <= 1'b0;
         dq_s1_q <= 16'h0000;
         dq_s2_q <= 16'h0000;
      end else if (i_clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         write_q <= write_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         dq_s1_q <= i_dq_in;
         dq_s2_q <= dq_s1_q;
      end
   end

   // Strobes: address stable before the falling edge, data past the rise
   assign o_ce_n = (state_q == st_idle);
   assign o_we_n = !(write_q && state_q == st_pulse);
   assign o_oe_n = !(!write_q && state_q == st_pulse);
   assign o_addr = addr_q;
   assign o_dq_out = wdata_q;
   assign o_dq_oe = write_q && state_q != st_idle;
   assign o_done = done_q;
   assign o_rdata = rdata_q;
endmodule : flash_bus_cycle

// ### logic/flash_cmd_host.sv
// Functional notes
// - Resume once to continue erase; repeats ignored; resuspend ok.
// - Suspend and resume are one write each, any address.
// - Buffer: unlocks, 25@sector, count-1@sector, pairs, 29@sector.
// - Abort recovery: two unlocks then F0 at 555.
// - Bypass program: A0 at any address, then address and data.
// - Bypass exit: 90 then 00, any addresses.
// - Reset command leaves identify mode or recovers from error.
`timescale 1ns/1ps
`include "flash_host_defs.svh"

module flash_cmd_host #(
   parameter int SUSPEND_WAIT = `T_SUSPEND_US * 1000 / `CLK_PERIOD_NS,
   parameter int ACCEPT_WAIT = `T_ACCEPT_US * 1000 / `CLK_PERIOD_NS
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // Command port
   input wire logic i_cmd_valid,
   input wire flash_host_pkg::op_type i_cmd_op,
   input wire logic [21:0] i_cmd_addr,
   input wire logic [15:0] i_cmd_data,
   output logic o_cmd_ready,
   output logic o_rsp_valid,
   output logic [15:0] o_rsp_data,
   // Host view of the device mode
   output logic o_erase_pending,
   output logic o_suspended,
   output logic o_bypass,
   // Flash pins
   output logic o_ce_n,
   output logic o_we_n,
   output logic o_oe_n,
   output logic [21:0] o_addr,
   output logic [15:0] o_dq_out,
   output logic o_dq_oe,
   input wire logic [15:0] i_dq_in
);
   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_cycle = 4'h2,
      st_wait = 4'h4,
      st_done = 4'h8
   } host_state_type;

   host_state_type state_q, state_d;
   flash_host_pkg::op_type op_q, op_d;
   logic [2:0] step_q, step_d;
   logic [2:0] last_q, last_d;
   logic [21:0] caddr_q, caddr_d;
   logic [15:0] cdata_q, cdata_d;
   logic [15:0] rsp_q, rsp_d;
   logic rsp_v_q, rsp_v_d;
   logic [15:0] wait_q, wait_d;
   logic erase_q, erase_d;
   logic susp_q, susp_d;
   logic bypass_q, bypass_d;
   logic cyc_start, cyc_write, cyc_done;
   logic [21:0] cyc_addr;
   logic [15:0] cyc_data, cyc_rdata;
   logic legal;

   always_comb begin
      unique case (i_cmd_op)
         flash_host_pkg::op_suspend: legal = erase_q && !susp_q;
         flash_host_pkg::op_resume: legal = susp_q;
         flash_host_pkg::op_bypass_program,
         flash_host_pkg::op_bypass_exit: legal = bypass_q;
         flash_host_pkg::op_chip_erase,
         flash_host_pkg::op_sector_erase: legal = !susp_q;
         default: legal = 1'b1;
      endcase
   end

   // Sequence table: address and data for each write step
   always_comb begin
      cyc_write = 1'b1;
      cyc_addr = `ADDR_UNLOCK1;
      cyc_data = `DATA_UNLOCK1;
      if (step_q == 3'h1) begin
         cyc_addr = `ADDR_UNLOCK2;
         cyc_data = `DATA_UNLOCK2;
      end
      unique case (op_q)
         flash_host_pkg::op_read: begin
            cyc_write = 1'b0;
            cyc_addr = caddr_q;
         end
         flash_host_pkg::op_ident: begin
            if (step_q == 3'h2) begin
               cyc_data = `CMD_AUTOSEL;
            end else if (step_q == 3'h3) begin
               cyc_write = 1'b0;
               cyc_addr = caddr_q;
            end else if (step_q == 3'h4) begin
               cyc_addr = `ADDR_ZERO;
               cyc_data = `CMD_RESET;
            end
         end
         flash_host_pkg::op_program: begin
            if (step_q == 3'h2) begin
               cyc_data = `CMD_PROGRAM;
            end else if (step_q == 3'h3) begin
               cyc_addr = caddr_q;
               cyc_data = cdata_q;
            end
         end
         flash_host_pkg::op_buf_start: begin
            if (step_q == 3'h2) begin
               cyc_addr = caddr_q;
               cyc_data = `CMD_BUF_LOAD;
            end else if (step_q == 3'h3) begin
               cyc_addr = caddr_q;
               cyc_data = cdata_q;
            end
         end
         flash_host_pkg::op_buf_word: begin
            cyc_addr = caddr_q;
            cyc_data = cdata_q;
         end
         flash_host_pkg::op_buf_commit: begin
            cyc_addr = caddr_q;
            cyc_data = `CMD_BUF_COMMIT;
         end
         flash_host_pkg::op_buf_abort: begin
            if (step_q == 3'h2) begin
               cyc_data = `CMD_RESET;
            end
         end
         flash_host_pkg::op_bypass_enter: begin
            if (step_q == 3'h2) begin
               cyc_data = `CMD_BYPASS;
            end
         end
         flash_host_pkg::op_bypass_program: begin
            cyc_addr = caddr_q;
            cyc_data = (step_q == 3'h0) ? `CMD_PROGRAM : cdata_q;
         end
         flash_host_pkg::op_bypass_exit: begin
            cyc_addr = caddr_q;
            cyc_data = (step_q == 3'h0) ? `CMD_AUTOSEL : `CMD_EXIT_DATA;
         end
         flash_host_pkg::op_chip_erase,
         flash_host_pkg::op_sector_erase: begin
            if (step_q == 3'h2) begin
               cyc_data = `CMD_ERASE_SETUP;
            end else if (step_q == 3'h4) begin
               cyc_addr = `ADDR_UNLOCK2;
               cyc_data = `DATA_UNLOCK2;
            end else if (step_q == 3'h5) begin
               if (op_q == flash_host_pkg::op_chip_erase) begin
                  cyc_data = `CMD_CHIP_ERASE;
               end else begin
                  cyc_addr = caddr_q;
                  cyc_data = `CMD_SECTOR_ERASE;
               end
            end
         end
         flash_host_pkg::op_suspend: begin
            cyc_addr = caddr_q;
            cyc_data = `CMD_SUSPEND;
         end
         flash_host_pkg::op_resume: begin
            cyc_addr = caddr_q;
            cyc_data = `CMD_RESUME;
         end
         flash_host_pkg::op_secure_enter: begin
            if (step_q == 3'h2) begin
               cyc_data = `CMD_SECURE_ENTER;
            end
         end
         flash_host_pkg::op_secure_exit: begin
            if (step_q == 3'h2) begin
               cyc_data = `CMD_AUTOSEL;
            end else if (step_q == 3'h3) begin
               cyc_addr = caddr_q;
               cyc_data = `CMD_EXIT_DATA;
            end
         end
      endcase
   end

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      step_d = step_q;
      last_d = last_q;
      caddr_d = caddr_q;
      cdata_d = cdata_q;
      rsp_d = rsp_q;
      rsp_v_d = 1'b0;
      wait_d = wait_q;
      erase_d = erase_q;
      susp_d = susp_q;
      bypass_d = bypass_q;
      cyc_start = 1'b0;
      unique case (state_q)
         st_idle: begin
            if (i_cmd_valid) begin
               op_d = i_cmd_op;
               caddr_d = i_cmd_addr;
               cdata_d = i_cmd_data;
               step_d = 3'h0;
               state_d = legal ? st_cycle : st_done;
               unique case (i_cmd_op)
                  flash_host_pkg::op_read,
                  flash_host_pkg::op_buf_word,
                  flash_host_pkg::op_buf_commit,
                  flash_host_pkg::op_suspend,
                  flash_host_pkg::op_resume: last_d = 3'h0;
                  flash_host_pkg::op_bypass_program,
                  flash_host_pkg::op_bypass_exit: last_d = 3'h1;
                  flash_host_pkg::op_buf_abort,
                  flash_host_pkg::op_bypass_enter,
                  flash_host_pkg::op_secure_enter: last_d = 3'h2;
                  flash_host_pkg::op_program,
                  flash_host_pkg::op_buf_start,
                  flash_host_pkg::op_secure_exit: last_d = 3'h3;
                  flash_host_pkg::op_ident: last_d = 3'h4;
                  flash_host_pkg::op_chip_erase,
                  flash_host_pkg::op_sector_erase: last_d = 3'h5;
               endcase
            end
         end
         st_cycle: begin
            cyc_start = 1'b1;
            state_d = st_wait;
         end
         st_wait: begin
            if (cyc_done) begin
               if (!cyc_write) begin
                  rsp_d = cyc_rdata;
               end
               if (step_q == last_q) begin
                  state_d = st_done;
                  wait_d = 16'h0000;
                  unique case (op_q)
                     flash_host_pkg::op_sector_erase: begin
                        erase_d = 1'b1;
                        wait_d = 16'(ACCEPT_WAIT);
                     end
                     flash_host_pkg::op_suspend: begin
                        susp_d = 1'b1;
                        wait_d = 16'(SUSPEND_WAIT);
                     end
                     flash_host_pkg::op_resume: susp_d = 1'b0;
                     flash_host_pkg::op_bypass_enter: bypass_d = 1'b1;
                     flash_host_pkg::op_bypass_exit: bypass_d = 1'b0;
                     default: begin
                     end
                  endcase
               end else begin
                  step_d = step_q + 3'h1;
                  state_d = st_cycle;
               end
            end
         end
         st_done: begin
            // Waiting here blocks new commands until the device settles
            if (wait_q != 16'h0000) begin
               wait_d = wait_q - 16'h0001;
            end else begin
               rsp_v_d = 1'b1;
               state_d = st_idle;
            end
         end
         default: state_d = st_idle;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_q <= st_idle;
         op_q <= flash_host_pkg::op_read;
         step_q <= 3'h0;
         last_q <= 3'h0;
         caddr_q <= 22'h000000;
         cdata_q <= 16'h0000;
         rsp_q <= 16'h0000;
         rsp_v_q <= 1'b0;
         wait_q <= 16'h0000;
         erase_q <= 1'b0;
         susp_q <= 1'b0;
         bypass_q <= 1'b0;
      end else if (i_clk_en) begin
         state_q <= state_d;
         op_q <= op_d;
         step_q <= step_d;
         last_q <= last_d;
         caddr_q <= caddr_d;
         cdata_q <= cdata_d;
         rsp_q <= rsp_d;
         rsp_v_q <= rsp_v_d;
         wait_q <= wait_d;
         erase_q <= erase_d;
         susp_q <= susp_d;
         bypass_q <= bypass_d;
      end
   end

   flash_bus_cycle u_cycle (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_clk_en(i_clk_en),
      .i_start(cyc_start),
      .i_write(cyc_write),
      .i_addr(cyc_addr),
      .i_data(cyc_data),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .o_ce_n(o_ce_n),
      .o_we_n(o_we_n),
      .o_oe_n(o_oe_n),
      .o_addr(o_addr),
      .o_dq_out(o_dq_out),
      .o_dq_oe(o_dq_oe),
      .i_dq_in(i_dq_in)
   );

   assign o_cmd_ready = (state_q == st_idle);
   assign o_rsp_valid = rsp_v_q;
   assign o_rsp_data = rsp_q;
   assign o_erase_pending = erase_q;
   assign o_suspended = susp_q;
   assign o_bypass = bypass_q;
endmodule : flash_cmd_host

// ### tb/flash_cmd_host_assertions.sv
`timescale 1ns/1ps
module flash_cmd_host_assertions #(
   parameter int SUSPEND_WAIT = 2500,
   parameter int ACCEPT_WAIT = 6250
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   // Command port
   input wire logic i_cmd_valid,
   input wire flash_host_pkg::op_type i_cmd_op,
   input wire logic o_cmd_ready,
   input wire logic o_rsp_valid,
   // Mode flags
   input wire logic o_erase_pending,
   input wire logic o_suspended,
   input wire logic o_bypass,
   // Flash pins
   input wire logic o_ce_n,
   input wire logic o_we_n,
   input wire logic o_oe_n,
   input wire logic [21:0] o_addr,
   input wire logic [15:0] o_dq_out,
   input wire logic o_dq_oe
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   logic take;
   assign take = i_cmd_valid && o_cmd_ready && i_clk_en;
   // Refused command answers without any bus cycle
   sequence s_quiet;
      o_ce_n throughout ##[1:3] o_rsp_valid;
   endsequence
   sequence s_take(flash_host_pkg::op_type op);
      take && i_cmd_op == op;
   endsequence
   a_strobe_excl: assert property (o_we_n || o_oe_n)
      else $error("write and read strobes low together");
   a_write_sel: assert property (!o_we_n |-> !o_ce_n && o_dq_oe)
      else $error("write strobe without select or data drive");
   a_addr_hold: assert property (!o_we_n && !$past(o_we_n)
      |-> $stable(o_addr))
      else $error("address moved during write pulse");
   a_data_hold: assert property ($rose(o_we_n)
      |-> o_dq_oe && $stable(o_dq_out))
      else $error("data not held to write strobe rise");
   a_idle_bus: assert property (o_cmd_ready |-> o_ce_n && !o_dq_oe)
      else $error("bus active while idle");
   a_susp_cause: assert property ($rose(o_suspended)
      |-> o_erase_pending)
      else $error("suspended without sector erase");
   a_susp_refuse: assert property (s_take(flash_host_pkg::op_suspend)
      ##0 !(o_erase_pending && !o_suspended) |-> s_quiet)
      else $error("suspend not refused");
   a_resume_refuse: assert property (s_take(flash_host_pkg::op_resume)
      ##0 !o_suspended |-> s_quiet)
      else $error("resume not refused");
   a_bypass_refuse: assert property (s_take(flash_host_pkg::op_bypass_program)
      ##0 !o_bypass |-> s_quiet)
      else $error("bypass program outside bypass mode");
endmodule : flash_cmd_host_assertions

bind flash_cmd_host flash_cmd_host_assertions #(
   .SUSPEND_WAIT(SUSPEND_WAIT), .ACCEPT_WAIT(ACCEPT_WAIT)
) u_check (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en),
   .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
   .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
   .o_erase_pending(o_erase_pending), .o_suspended(o_suspended),
   .o_bypass(o_bypass), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
   .o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq_out(o_dq_out),
   .o_dq_oe(o_dq_oe)
);

// ### tb/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model #(
   // Arbitrary identification values
   parameter logic [15:0] MAKER_CODE = 16'h00c5,
   parameter logic [15:0] PART_CODE = 16'h1a01
) (
   // Flash pins
   input wire logic i_ce_n,
   input wire logic i_we_n,
   input wire logic i_oe_n,
   input wire logic [21:0] i_addr,
   input wire logic [15:0] i_dq,
   output logic [15:0] o_dq
);
   logic [15:0] mem [logic [21:0]];
   logic [21:0] a_lat = 22'h000000;
   logic [15:0] rd_v = 16'h0000;
   logic [15:0] cnt = 16'h0000;
   logic [6:0] sec = 7'h00;
   logic [3:0] cyc = 4'h0;
   logic ident = 1'b0;
   logic bypass = 1'b0;
   logic erasing = 1'b0;
   logic susp = 1'b0;
   logic secure = 1'b0;
   wire wr_n = i_we_n | i_ce_n;
   wire rd_n = i_oe_n | i_ce_n;
   // Released bus shows the inverse, never a stale word
   assign o_dq = rd_n ? ~rd_v : rd_v;

   always @(rd_n or i_addr or susp or ident or secure) begin
      // status byte in the erase sector
      if (rd_n) rd_v = rd_v;
      else if (erasing && i_addr[21:15] == sec) rd_v = {8'h00, susp, 7'h00};
      else if (ident) rd_v = i_addr[7:0] == 8'h00 ? MAKER_CODE :
         i_addr[7:0] == 8'h01 ? PART_CODE : 16'h0000;
      else if (secure) rd_v = 16'h0000;
      else rd_v = mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
   end

   // address on later fall, data on first rise
   always @(negedge wr_n) a_lat = i_addr;
   always @(posedge wr_n) wr(a_lat, i_dq);

   task automatic wr(input logic [21:0] a, input logic [15:0] d);
      logic ul;
      ul = d[7:0] == 8'haa && a == 22'h000555;
      if (erasing && !susp) begin
         susp = d[7:0] == 8'hb0;
         return;
      end
      case (cyc)
         4'h0: begin
            if (susp && d[7:0] == 8'h30) susp = 1'b0;
            else if (bypass && d[7:0] == 8'ha0) cyc = 4'h3;
            else if (bypass && d[7:0] == 8'h90) cyc = 4'h9;
            else if (ident && d == 16'h0000) {ident, secure} = 2'h0;
            else if (d[7:0] == 8'hf0) ident = 1'b0;
            else cyc = {3'h0, ul};
         end
         4'h1: cyc = d[7:0] == 8'h55 && a == 22'h0002aa ? 4'h2 : 4'h0;
         4'h2: begin
            cyc = 4'h0;
            case (d[7:0])
               8'ha0: cyc = 4'h3;
               8'h25: cyc = 4'h7;
               8'h80: cyc = 4'h4;
               8'h20: bypass = 1'b1;
               8'h88: secure = 1'b1;
               8'h90: ident = 1'b1;
               default: ident = 1'b0;
            endcase
         end
         4'h3: begin
            mem[a] = d;
            cyc = 4'h0;
         end
         4'h4: cyc = ul ? 4'h5 : 4'h0;
         4'h5: cyc = d[7:0] == 8'h55 && a == 22'h0002aa ? 4'h6 : 4'h0;
         4'h6: begin
            cyc = 4'h0;
            if (d[7:0] == 8'h10) mem.delete();
            erasing = erasing || d[7:0] == 8'h30;
            if (d[7:0] == 8'h30) sec = a[21:15];
         end
         4'h7: begin
            cnt = d;
            cyc = 4'h8;
         end
         4'h8: begin
            mem[a] = d;
            cyc = cnt == 16'h0000 ? 4'ha : 4'h8;
            cnt = cnt - 16'h0001;
         end
         4'h9: begin
            bypass = bypass && d != 16'h0000;
            cyc = 4'h0;
         end
         default: cyc = {3'h0, ul};
      endcase
   endtask : wr
endmodule : flash_dev_model

// ### tb/flash_cmd_host_tb_top.sv
`timescale 1ns/1ps
module flash_cmd_host_tb_top;
   // Arbitrary identification values
   localparam logic [15:0] MAKER = 16'h00c5;
   localparam logic [15:0] PART = 16'h1a01;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_cmd_valid = 1'b0;
   flash_host_pkg::op_type i_cmd_op = flash_host_pkg::op_read;
   logic [21:0] i_cmd_addr = 22'h000000;
   logic [15:0] i_cmd_data = 16'h0000;
   logic o_cmd_ready, o_rsp_valid, o_erase_pending, o_suspended;
   logic o_bypass, o_ce_n, o_we_n, o_oe_n, o_dq_oe;
   logic [21:0] o_addr;
   logic [15:0] o_rsp_data, o_dq_out, dq_in, dq_wire;
   int error_cnt = 0;
   int n_tests = 0;

   always #4 i_sys_clk = ~i_sys_clk;
   assign dq_wire = o_dq_oe ? o_dq_out : dq_in;

   flash_cmd_host #(.SUSPEND_WAIT(4), .ACCEPT_WAIT(4)) DUT (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'b1),
      .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
      .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data),
      .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
      .o_rsp_data(o_rsp_data), .o_erase_pending(o_erase_pending),
      .o_suspended(o_suspended), .o_bypass(o_bypass),
      .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
      .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
      .i_dq_in(dq_wire)
   );
   flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (
      .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
      .i_addr(o_addr), .i_dq(dq_wire), .o_dq(dq_in)
   );

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic fchk(input logic seen, input logic exp);
      check({15'h0000, seen}, {15'h0000, exp});
   endtask : fchk

   // Bounded wait; slow answers are cut off as mismatches
   task automatic cmd(input flash_host_pkg::op_type op,
         input logic [21:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_cmd_valid <= 1'b1;
      i_cmd_op <= op;
      i_cmd_addr <= a;
      i_cmd_data <= d;
      @(negedge i_sys_clk);
      @(posedge i_sys_clk);
      i_cmd_valid <= 1'b0;
      while (o_rsp_valid !== 1'b1 && n < 3000) begin
         @(negedge i_sys_clk);
         n++;
      end
      if (n >= 3000) begin
         error_cnt++;
         $display("BAD at %0t: no answer", $time);
         end_of_test();
      end
   endtask : cmd

   task automatic rd_chk(input logic [21:0] a, input logic [15:0] e);
      cmd(flash_host_pkg::op_read, a, 16'h0000);
      check(o_rsp_data, e);
   endtask : rd_chk

   task automatic t_basic();
      cmd(flash_host_pkg::op_program, 22'h000100, 16'h5a5a);
      rd_chk(22'h000100, 16'h5a5a);
      cmd(flash_host_pkg::op_ident, 22'h000000, 16'h0000);
      check(o_rsp_data, MAKER);
      cmd(flash_host_pkg::op_ident, 22'h000001, 16'h0000);
      check(o_rsp_data, PART);
      rd_chk(22'h000100, 16'h5a5a);
      cmd(flash_host_pkg::op_secure_enter, 22'h000000, 16'h0000);
      rd_chk(22'h000100, 16'h0000);
      cmd(flash_host_pkg::op_secure_exit, 22'h000000, 16'h0000);
      rd_chk(22'h000100, 16'h5a5a);
      $display("test basic done");
   endtask : t_basic

   task automatic t_bypass();
      cmd(flash_host_pkg::op_bypass_program, 22'h000200, 16'h1111);
      rd_chk(22'h000200, 16'hffff);
      cmd(flash_host_pkg::op_bypass_enter, 22'h000000, 16'h0000);
      fchk(o_bypass, 1'b1);
      cmd(flash_host_pkg::op_bypass_program, 22'h000200, 16'h1111);
      cmd(flash_host_pkg::op_bypass_program, 22'h000201, 16'h2222);
      rd_chk(22'h000201, 16'h2222);
      cmd(flash_host_pkg::op_bypass_exit, 22'h000000, 16'h0000);
      fchk(o_bypass, 1'b0);
      cmd(flash_host_pkg::op_program, 22'h000202, 16'h3333);
      rd_chk(22'h000202, 16'h3333);
      cmd(flash_host_pkg::op_buf_start, 22'h008000, 16'h0001);
      cmd(flash_host_pkg::op_buf_word, 22'h008010, 16'habcd);
      cmd(flash_host_pkg::op_buf_word, 22'h008011, 16'hbcde);
      cmd(flash_host_pkg::op_buf_commit, 22'h008000, 16'h0000);
      rd_chk(22'h008011, 16'hbcde);
      cmd(flash_host_pkg::op_buf_abort, 22'h000000, 16'h0000);
      cmd(flash_host_pkg::op_program, 22'h000203, 16'h4321);
      rd_chk(22'h000203, 16'h4321);
      $display("test bypass and buffer done");
   endtask : t_bypass

   task automatic t_erase();
      cmd(flash_host_pkg::op_chip_erase, 22'h000000, 16'h0000);
      rd_chk(22'h000100, 16'hffff);
      cmd(flash_host_pkg::op_suspend, 22'h000000, 16'h0000);
      fchk(o_suspended, 1'b0);
      cmd(flash_host_pkg::op_resume, 22'h000000, 16'h0000);
      fchk(o_suspended, 1'b0);
      cmd(flash_host_pkg::op_sector_erase, 22'h018000, 16'h0000);
      fchk(o_erase_pending, 1'b1);
      rd_chk(22'h018004, 16'h0000);
      cmd(flash_host_pkg::op_suspend, 22'h000000, 16'h0000);
      fchk(o_suspended, 1'b1);
      rd_chk(22'h018004, 16'h0080);
      cmd(flash_host_pkg::op_program, 22'h000300, 16'h4444);
      rd_chk(22'h000300, 16'h4444);
      cmd(flash_host_pkg::op_ident, 22'h000000, 16'h0000);
      check(o_rsp_data, MAKER);
      rd_chk(22'h018004, 16'h0080);
      cmd(flash_host_pkg::op_resume, 22'h000000, 16'h0000);
      fchk(o_suspended, 1'b0);
      cmd(flash_host_pkg::op_resume, 22'h000000, 16'h0000);
      rd_chk(22'h018004, 16'h0000);
      cmd(flash_host_pkg::op_suspend, 22'h000000, 16'h0000);
      fchk(o_suspended, 1'b1);
      $display("test erase and suspend done");
   endtask : t_erase

   initial begin
      repeat (6) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      t_basic();
      t_bypass();
      t_erase();
      end_of_test();
   end
endmodule : flash_cmd_host_tb_top
